//--- rtl/cir_router.sv
/*
 cascaded interrupt router: two priority controllers, line routing,
 nonmaskable gating and acknowledge vector delivery to the host core.
 assumes all inputs synchronous to ref_clk_in; masks come from host logic.
*/
`timescale 1ns/1ps
`default_nettype none
module cir_router
#(
	parameter int NUM_LINES = cir_pkg::NUM_LINES
)
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	input  wire logic        clk_en_in,
	// peripheral request sources, index = line number
	input  wire logic [15:0] periph_req_in,
	input  wire logic        legacy_line2_req_in,
	input  wire logic        coproc_err_req_in,
	input  wire logic        second_parallel_port_req_in,
	// bus interface requests and routing
	input  wire logic        bus_irq_req_in,
	input  wire logic [1:0]  bus_route_sel_in,
	input  wire logic        line5_route_jumper_a_in,
	input  wire logic        line5_route_jumper_b_in,
	// nonmaskable sources
	input  wire logic        parity_err_in,
	input  wire logic        nmi_enable_in,
	// host side
	input  wire logic [15:0] mask_in,
	input  wire logic        ack_in,
	output logic             irq_out,
	output logic             nmi_out,
	output logic [7:0]       vector_out,
	output logic             vector_valid_out
);
	////////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// the line map and vector bases assume exactly two 8-input controllers
	if (NUM_LINES != 16)
	begin : g_bad_lines
		$error("cir_router serves exactly sixteen lines");
	end
	if (cir_pkg::LINES_PER_PIC != 8)
	begin : g_bad_width
		$error("cir_router needs eight inputs per controller");
	end
	if (cir_pkg::VEC_TABLE != 256)
	begin : g_bad_table
		$error("an 8-bit vector needs a 256-entry table");
	end
	// the cascade input and line 5 must sit on the master
	if ((cir_pkg::CASCADE_LINE >= 4'h8) || (cir_pkg::LINE5 >= 4'h8))
	begin : g_bad_master_map
		$error("cascade input and line 5 belong to the master");
	end
	// these lines take their vectors from the slave base
	if ((cir_pkg::LEGACY_LINE < 4'h8) || (cir_pkg::COPROC_LINE < 4'h8)
		|| (cir_pkg::BUS_PRI_LINE < 4'h8) || (cir_pkg::BUS_ALT_LINE < 4'h8))
	begin : g_bad_slave_map
		$error("legacy, coprocessor and bus lines belong to the slave");
	end
	// or-ing the input index into a base only works on an 8-aligned base
	if ((cir_pkg::MASTER_BASE[2:0] != 3'h0) || (cir_pkg::SLAVE_BASE[2:0] != 3'h0))
	begin : g_bad_base
		$error("vector bases must be multiples of eight");
	end

	////////////////////////////////////////////////////////////////////////////////////
	// line routing

	// bus route select: 0 primary line, 1 alternate line, 2 line 5, 3 nonmaskable
	wire logic        line5_bus;
	wire logic [15:0] lines;
	wire logic        nmi_src;
	assign line5_bus = ({line5_route_jumper_b_in, line5_route_jumper_a_in}
		== cir_pkg::JMP_BUS_ROUTE); // [R9]
	wire logic        bus_to_pri;
	wire logic        bus_to_alt;
	wire logic        bus_to_line5;
	wire logic        bus_to_nmi;
	// one code picks one route, so a bus request never shows on two lines at once
	assign bus_to_pri   = bus_irq_req_in & (bus_route_sel_in == 2'h0); // [R7]
	assign bus_to_alt   = bus_irq_req_in & (bus_route_sel_in == 2'h1); // [R8]
	// code 2 without both jumpers is lost: the jumpers must be fitted first
	assign bus_to_line5 = bus_irq_req_in & (bus_route_sel_in == 2'h2); // [R10]
	assign bus_to_nmi   = bus_irq_req_in & (bus_route_sel_in == 2'h3); // [R6]
	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_line
			if (g == cir_pkg::CASCADE_LINE)
				assign lines[g] = 1'b0; // [R3]
			else if (g == cir_pkg::LEGACY_LINE)
				assign lines[g] = legacy_line2_req_in | periph_req_in[g]; // [R5]
			else if (g == cir_pkg::COPROC_LINE)
				assign lines[g] = coproc_err_req_in; // [R4]
			else if (g == cir_pkg::BUS_PRI_LINE)
				assign lines[g] = periph_req_in[g] | bus_to_pri; // [R7]
			else if (g == cir_pkg::BUS_ALT_LINE)
				assign lines[g] = periph_req_in[g] | bus_to_alt; // [R8]
			// with the jumpers fitted the parallel port request is cut off, not merged
			else if (g == cir_pkg::LINE5)
				assign lines[g] = line5_bus
					? bus_to_line5
					: second_parallel_port_req_in; // [R9] [R10]
			else
				assign lines[g] = periph_req_in[g]; // [R1]
		end
	endgenerate
	assign nmi_src = parity_err_in | bus_to_nmi; // [R6]

	////////////////////////////////////////////////////////////////////////////////////
	// master and slave controllers

	wire logic       s_any;
	wire logic [2:0] s_idx;
	wire logic       m_any;
	wire logic [2:0] m_idx;
	wire logic [7:0] m_req;
	cir_prio8 u_slave
	(
		.req_in  (lines[15:8]),
		.mask_in (mask_in[15:8]),
		.any_out (s_any),
		.idx_out (s_idx)
	); // [R2]
	// slave result enters master at input 2, so it ranks there
	assign m_req = {lines[7:3], s_any, lines[1:0]}; // [R2] [R11]
	cir_prio8 u_master
	(
		.req_in  (m_req),
		.mask_in ({mask_in[7:3], 1'b0, mask_in[1:0]}),
		.any_out (m_any),
		.idx_out (m_idx)
	);
	wire logic       from_slave;
	wire logic [7:0] win_vec;
	assign from_slave = (m_idx == cir_pkg::CASCADE_LINE[2:0]);
	wire logic [7:0] s_vec;
	wire logic [7:0] m_vec;
	// base+line yields 0D for line 5, 73 for 11, 74 for 12
	assign s_vec   = cir_pkg::SLAVE_BASE | {5'h00, s_idx}; // [R7] [R8]
	assign m_vec   = cir_pkg::MASTER_BASE | {5'h00, m_idx}; // [R10]
	assign win_vec = from_slave ? s_vec : m_vec; // [R11]

	////////////////////////////////////////////////////////////////////////////////////
	// acknowledge handshake

	cir_pkg::cir_state_t state_r;
	cir_pkg::cir_state_t state_nxt;
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			cir_pkg::CIR_IDLE: if (m_any) state_nxt = cir_pkg::CIR_PEND;
			cir_pkg::CIR_PEND:
			begin
				if (ack_in) state_nxt = cir_pkg::CIR_ACK;
				else if (!m_any) state_nxt = cir_pkg::CIR_IDLE;
			end
			cir_pkg::CIR_ACK: if (!ack_in) state_nxt = cir_pkg::CIR_IDLE;
			default: state_nxt = cir_pkg::CIR_IDLE;
		endcase
	end

	wire logic take_ack;
	assign take_ack = (state_r == cir_pkg::CIR_PEND) && ack_in;

	////////////////////////////////////////////////////////////////////////////////////
	// output registers

	// irq mirrors the pending state, so an ack is only offered while it can be taken
	wire logic       irq_nxt;
	wire logic       nmi_nxt;
	wire logic       valid_nxt;
	wire logic [7:0] vector_nxt;
	assign irq_nxt    = (state_nxt == cir_pkg::CIR_PEND); // [R11]
	assign nmi_nxt    = nmi_src & nmi_enable_in; // [R6]
	assign valid_nxt  = take_ack; // [R11]
	// the vector holds between acks so a slow host can still read it late
	assign vector_nxt = take_ack ? win_vec : vector_out; // [R11]

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			state_r <= cir_pkg::CIR_IDLE;
		else if (clk_en_in)
			state_r <= state_nxt;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			irq_out <= 1'b0;
		else if (clk_en_in)
			irq_out <= irq_nxt;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			nmi_out <= 1'b0;
		else if (clk_en_in)
			nmi_out <= nmi_nxt;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			vector_out <= cir_pkg::VEC_RESET;
		else if (clk_en_in)
			vector_out <= vector_nxt;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			vector_valid_out <= 1'b0;
		else if (clk_en_in)
			vector_valid_out <= valid_nxt;
	end
endmodule
`default_nettype wire

//--- rtl/cir_pkg.sv
/*
 cascaded interrupt router constants: line map, vectors, jumper codes.
 assumes a single 40 MHz clock domain and no software-visible registers.
*/
// Contract
// [R1] sixteen maskable request lines and one nonmaskable, each tied to a 256-entry vector table
// [R2] master controller serves lines 0-7, slave serves 8-15, slave cascades into master
// [R3] master input 2 carries only the slave cascade, never a peripheral source
// [R4] slave input 13 is reserved for the coprocessor error request
// [R5] expansion legacy line 2 is wired to slave input 9, also on stacked port
// [R6] nonmaskable request uses vector 02, carries parity and bus errors, needs enabling
// [R7] primary bus interrupt routing uses slave line 11, vector 73 hex
// [R8] alternate bus interrupt routing uses slave line 12, vector 74 hex
// [R9] two jumpers choose line 5 for second parallel port or bus interrupts
// [R10] line 5 bus interrupts go out on vector 0D hex, shared with fixed disk
// [R11] acknowledge returns highest-priority unmasked pending vector; slave ranks at master input 2
package cir_pkg;
	localparam int          NUM_LINES     = 16;
	localparam int          LINES_PER_PIC = 8;
	localparam int          VEC_TABLE     = 256;
	localparam logic [3:0]  CASCADE_LINE  = 4'h2;
	localparam logic [3:0]  LEGACY_LINE   = 4'h9;
	localparam logic [3:0]  COPROC_LINE   = 4'hD;
	localparam logic [3:0]  BUS_PRI_LINE  = 4'hB;
	localparam logic [3:0]  BUS_ALT_LINE  = 4'hC;
	localparam logic [3:0]  LINE5         = 4'h5;
	localparam logic [7:0]  MASTER_BASE   = 8'h08;
	localparam logic [7:0]  SLAVE_BASE    = 8'h70;
	localparam logic [7:0]  NMI_VECTOR    = 8'h02;
	localparam logic [7:0]  BUS_PRI_VEC   = 8'h73;
	localparam logic [7:0]  BUS_ALT_VEC   = 8'h74;
	localparam logic [7:0]  LINE5_VEC     = 8'h0D;
	localparam logic [15:0] MASK_RESET    = 16'hFFFF;
	localparam logic [7:0]  VEC_RESET     = 8'h00;
	// jumper pair code: both fitted selects bus interrupts on line 5
	localparam logic [1:0]  JMP_BUS_ROUTE = 2'h3;
	typedef enum logic [2:0]
	{
		CIR_IDLE = 3'b001,
		CIR_PEND = 3'b010,
		CIR_ACK  = 3'b100
	} cir_state_t;
endpackage

//--- rtl/cir_prio8.sv
/*
 one 8-input priority resolver; lowest pending unmasked input wins.
 assumes inputs synchronous to the clock; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module cir_prio8
(
	// requests
	input  wire logic [7:0] req_in,
	input  wire logic [7:0] mask_in,
	// result
	output logic            any_out,
	output logic [2:0]      idx_out
);
	wire logic [7:0] live;
	assign live = req_in & ~mask_in;
	assign any_out = |live;
	always_comb
	begin
		idx_out = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (live[i])
				idx_out = i[2:0]; // [R11]
		end
	end
endmodule
`default_nettype wire

//--- bench/cir_router_assertions.sv
/*
 port checker for cir_router: nmi path, acknowledge and vector delivery.
 assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cir_router_assertions
#(
	parameter int NUM_LINES = 16
)
(
	input wire logic        ref_clk_in,
	input wire logic        reset_in,
	input wire logic        clk_en_in,
	input wire logic        bus_irq_req_in,
	input wire logic [1:0]  bus_route_sel_in,
	input wire logic        parity_err_in,
	input wire logic        nmi_enable_in,
	input wire logic [15:0] mask_in,
	input wire logic        ack_in,
	input wire logic        irq_out,
	input wire logic        nmi_out,
	input wire logic [7:0]  vector_out,
	input wire logic        vector_valid_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wire logic nmi_src = (parity_err_in | (bus_irq_req_in & (bus_route_sel_in == 2'h3)))
		& nmi_enable_in;
	a_nmi_route: assert property (clk_en_in |=> nmi_out == $past(nmi_src))
		else $error("nmi output wrong");
	a_valid_pulse: assert property (vector_valid_out |=> !vector_valid_out)
		else $error("vector valid too long");
	a_ack_taken: assert property (irq_out && ack_in && clk_en_in |=> vector_valid_out)
		else $error("ack not answered");
	a_ack_cause: assert property (vector_valid_out |-> $past(irq_out) && $past(ack_in))
		else $error("vector without ack");
	a_irq_drop: assert property (vector_valid_out |-> !irq_out)
		else $error("irq high with vector");
	a_vec_hold: assert property (!vector_valid_out && !$past(reset_in) |-> $stable(vector_out))
		else $error("vector moved");
	a_vec_range: assert property (vector_valid_out |-> vector_out != 8'h0A &&
		vector_out inside {[8'h08:8'h0F], [8'h70:8'h77]}) else $error("vector out of range");
	a_mask_all: assert property (clk_en_in && &mask_in |=> !irq_out)
		else $error("irq while masked");
endmodule
bind cir_router cir_router_assertions #(.NUM_LINES(NUM_LINES)) u_chk(.ref_clk_in, .reset_in,
	.clk_en_in, .bus_irq_req_in, .bus_route_sel_in, .parity_err_in, .nmi_enable_in, .mask_in,
	.ack_in, .irq_out, .nmi_out, .vector_out, .vector_valid_out);
`default_nettype wire

//--- bench/cir_host_model.sv
/*
 host core model: acknowledges irq_out at once or one cycle late.
 assumes the router takes ack at the edge after it rises.
*/
`timescale 1ns/1ps
`default_nettype none
module cir_host_model
(
	input  wire logic ref_clk_in,
	input  wire logic reset_in,
	input  wire logic irq_in,
	input  wire logic slow_in,
	output logic      ack_out
);
	logic seen_r;
	// ack lasts one cycle, so it is always low a cycle between takes
	always_ff @(posedge ref_clk_in)
	begin
		seen_r  <= irq_in && !reset_in;
		ack_out <= irq_in && !ack_out && (!slow_in || seen_r) && !reset_in;
	end
endmodule
`default_nettype wire

//--- bench/tb.sv
/*
 tb: cir_router with a host model; vector, priority and nmi checks.
 assumes a 40 MHz clock and a 3-cycle synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 0, rst = 1, leg = 0, cop = 0, lpt = 0, bus = 0, ja = 0, jb = 0;
	logic        par = 0, nen = 0, slow = 0, ack, irq, nmi, vv;
	logic [1:0]  rsel = 0;
	logic [15:0] req = 0, mask = 16'hFFFF;
	logic [7:0]  vec, s;
	int          error_cnt = 0, compares = 0;
	cir_router u_cir_router(.ref_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
		.periph_req_in(req), .legacy_line2_req_in(leg), .coproc_err_req_in(cop),
		.second_parallel_port_req_in(lpt), .bus_irq_req_in(bus), .bus_route_sel_in(rsel),
		.line5_route_jumper_a_in(ja), .line5_route_jumper_b_in(jb), .parity_err_in(par),
		.nmi_enable_in(nen), .mask_in(mask), .ack_in(ack), .irq_out(irq), .nmi_out(nmi),
		.vector_out(vec), .vector_valid_out(vv));
	cir_host_model u_cir_host_model(.ref_clk_in(clk), .reset_in(rst), .irq_in(irq),
		.slow_in(slow), .ack_out(ack));
	initial forever #12.5 clk = ~clk;
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one acknowledged vector, then requests drop and the router settles
	task go;
		for (int n = 0; n < 20 && vv !== 1'b1; n++) @(negedge clk);
		s = (vv === 1'b1) ? vec : 'x;
		@(posedge clk);
		{req, leg, cop, lpt, bus} <= '0;
		repeat (4) @(posedge clk);
	endtask
	task t_master;
		@(posedge clk);
		mask <= 16'h0001;
		req <= 16'h2089;
		go;
		check(s, 8'h0B);
		req <= 16'h2024;
		lpt <= 1'b1;
		go;
		check(s, 8'h0D);
	endtask
	task t_slave;
		slow <= 1'b1;
		bus <= 1'b1;
		go;
		check(s, 8'h73);
		rsel <= 2'h1;
		bus <= 1'b1;
		go;
		check(s, 8'h74);
		leg <= 1'b1;
		req <= 16'h0008;
		go;
		check(s, 8'h71);
		cop <= 1'b1;
		req <= 16'h4000;
		go;
		check(s, 8'h75);
	endtask
	task t_line5;
		{ja, jb, lpt, bus} <= 4'hE;
		rsel <= 2'h2;
		repeat (3) @(negedge clk);
		check({7'h00, irq}, 8'h00);
		@(posedge clk);
		bus <= 1'b1;
		go;
		check(s, 8'h0D);
	endtask
	// nmi has no vector port, so the output level is what is judged
	task t_nmi;
		par <= 1'b1;
		repeat (2) @(negedge clk);
		check({7'h00, nmi}, 8'h00);
		@(posedge clk);
		nen <= 1'b1;
		repeat (2) @(negedge clk);
		check({7'h00, nmi}, 8'h01);
		@(posedge clk);
		par <= 1'b0;
		rsel <= 2'h3;
		bus <= 1'b1;
		repeat (2) @(negedge clk);
		check({7'h00, nmi}, 8'h01);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_master;
		t_slave;
		t_line5;
		t_nmi;
		print_verdict;
	end
	initial
	begin
		#50us;
		error_cnt++;
		print_verdict;
	end
endmodule
`default_nettype wire
